/* File: pcdt_dma_seq.sv */
// Purpose: socket-side dma cycle sequencer with programmable setup, command and recovery
// Assumes: all inputs synchronous to core_clk; card signals active low where named _n
// Notes:   an internal period is four core clocks
//          card terminal count rides on the memory enables
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - setup phase lasts prescale times value plus one
// - command strobe lasts prescale times value plus one
// - recovery lasts prescale times value plus one
// - all phases counted in 40 ns periods
// - cycle starts 40 ns after request and acknowledge
// - dma read: setup signals, then write strobe
// - dma write: setup signals, then read strobe
// - dma read: terminal count on write enable
// - dma write: terminal count on output enable
// - wait stretches strobe, two periods after release
// - hold system request until write buffer drains
module pcdt_dma_seq (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  // register index/data port
  input  wire logic [7:0]               reg_index,
  input  wire logic                     reg_wr_en,
  input  wire logic [7:0]               reg_wdata,
  output logic [7:0]                    reg_rdata,
  // timing configuration
  input  wire logic                     timer_set_sel,
  input  wire logic [7:0]               phase_prescale_factor,
  input  wire logic                     dma_read_dir,
  // system side
  input  wire logic                     interrupt_line_nine_n,
  output logic                          interrupt_line_ten,
  input  wire logic                     vpp_valid_tc,
  output logic                          dma_cycle_done,
  // socket side
  input  wire logic                     sock_transfer_request,
  input  wire logic                     sock_fifo_empty,
  input  wire logic                     card_wait_n,
  input  wire logic                     card_sixteen_bit_io_flag_n,
  output pcdt_pkg::pcdt_card_pins_t     card_pins
);

  // registers
  logic [7:0] tmr_q [pcdt_pkg::NUM_TMR_REGS];  // timing registers, index 3A..3F
  logic       rst_done_q;                       // first clock after reset release seen
  logic [7:0] rst_val [pcdt_pkg::NUM_TMR_REGS]; // reset values in index order
  logic [2:0] wr_slot;                          // written slot, 0..5
  logic       wr_hit;                           // write lands on a timing register
  logic       idx_hit;                          // index names a timing register

  assign rst_val[0] = pcdt_pkg::RST_SETUP_SET0;
  assign rst_val[1] = pcdt_pkg::RST_COMMAND_SET0;
  assign rst_val[2] = pcdt_pkg::RST_RECOVER_SET0;
  assign rst_val[3] = pcdt_pkg::RST_SETUP_SET1;
  assign rst_val[4] = pcdt_pkg::RST_COMMAND_SET1;
  assign rst_val[5] = pcdt_pkg::RST_RECOVER_SET1;

  // decode the index into a slot of the timing block
  assign wr_slot = 3'(reg_index - pcdt_pkg::IDX_SETUP_SET0);
  assign idx_hit = (reg_index >= pcdt_pkg::IDX_SETUP_SET0) && (reg_index <= pcdt_pkg::IDX_RECOVER_SET1);
  assign wr_hit  = reg_wr_en && idx_hit;

  // one register per slot
  genvar gi;
  generate
    for (gi = 0; gi < pcdt_pkg::NUM_TMR_REGS; gi++) begin : g_tmr
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          tmr_q[gi] <= 8'h00;
        end else if (!rst_done_q) begin
          tmr_q[gi] <= rst_val[gi];  // constant load on the first clock after release
        end else if (wr_hit && (wr_slot == 3'(gi))) begin
          tmr_q[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  // marks that the reset values have been loaded
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rst_done_q <= 1'b0;
    end else begin
      rst_done_q <= 1'b1;
    end
  end

  // phase lengths
  logic [7:0]                  setup_val;    // active set setup value
  logic [7:0]                  cmd_val;      // active set command value
  logic [7:0]                  recov_val;    // active set recovery value
  logic [pcdt_pkg::CNT_W-1:0]  setup_len;    // setup periods
  logic [pcdt_pkg::CNT_W-1:0]  cmd_len;      // command periods
  logic [pcdt_pkg::CNT_W-1:0]  recov_len;    // recovery periods

  // select the active timer set
  assign setup_val = timer_set_sel ? tmr_q[3] : tmr_q[0];
  assign cmd_val   = timer_set_sel ? tmr_q[4] : tmr_q[1];
  assign recov_val = timer_set_sel ? tmr_q[5] : tmr_q[2];

  // length equals prescale times value plus one
  assign setup_len = pcdt_pkg::CNT_W'(phase_prescale_factor * setup_val) + 17'h00001;
  assign cmd_len   = pcdt_pkg::CNT_W'(phase_prescale_factor * cmd_val) + 17'h00001;
  assign recov_len = pcdt_pkg::CNT_W'(phase_prescale_factor * recov_val) + 17'h00001;

  // internal period divider
  pcdt_pkg::pcdt_state_t      state_q;   // current phase
  pcdt_pkg::pcdt_state_t      state_d;   // next phase
  logic [1:0] div_q;   // core cycles into the current period
  logic       tick;    // last core cycle of a period

  assign tick = (div_q == pcdt_pkg::TICK_LAST);

  // divider restarts while idle so the start delay is a whole period
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      div_q <= 2'h0;
    end else if (state_q == pcdt_pkg::ST_IDLE) begin
      div_q <= 2'h0;
    end else begin
      div_q <= tick ? 2'h0 : (div_q + 2'h1);
    end
  end

  // sequencer
  logic                       tmr_load;  // load the phase timer
  logic [pcdt_pkg::CNT_W-1:0] tmr_val;   // value to load
  logic                       tmr_last;  // final period of the phase
  logic                       tmr_exp;   // phase timer expires
  logic                       both_act;  // request and acknowledge both active
  logic                       dir_q;     // 1 for dma read, latched per cycle

  assign both_act = interrupt_line_ten && !interrupt_line_nine_n;

  // next-phase decision and timer load
  always_comb begin
    state_d  = state_q;
    tmr_load = 1'b0;
    tmr_val  = '0;
    case (state_q)
      pcdt_pkg::ST_IDLE: begin
        if (both_act) begin
          state_d  = pcdt_pkg::ST_START;
          tmr_load = 1'b1;
          tmr_val  = pcdt_pkg::CNT_W'(pcdt_pkg::START_TICKS);
        end
      end
      pcdt_pkg::ST_START: begin
        if (tmr_exp) begin
          state_d  = pcdt_pkg::ST_SETUP;
          tmr_load = 1'b1;
          tmr_val  = setup_len;
        end
      end
      pcdt_pkg::ST_SETUP: begin
        if (tmr_exp) begin
          state_d  = pcdt_pkg::ST_CMD;
          tmr_load = 1'b1;
          tmr_val  = cmd_len;
        end
      end
      pcdt_pkg::ST_CMD: begin
        // card wait moves the strobe to the hold phase, which ends two periods after release whatever the programmed length
        if (!card_wait_n) begin
          state_d  = pcdt_pkg::ST_HOLD;
          tmr_load = 1'b1;
          tmr_val  = pcdt_pkg::CNT_W'(pcdt_pkg::WAIT_HOLD_TICKS + 1);
        end else if (tmr_exp) begin
          state_d  = pcdt_pkg::ST_RECOV;
          tmr_load = 1'b1;
          tmr_val  = recov_len;
        end
      end
      pcdt_pkg::ST_HOLD: begin
        // reload while wait is held; the extra period covers the partial one
        if (!card_wait_n) begin
          tmr_load = 1'b1;
          tmr_val  = pcdt_pkg::CNT_W'(pcdt_pkg::WAIT_HOLD_TICKS + 1);
        end else if (tmr_exp) begin
          state_d  = pcdt_pkg::ST_RECOV;
          tmr_load = 1'b1;
          tmr_val  = recov_len;
        end
      end
      pcdt_pkg::ST_RECOV: begin
        if (tmr_exp) begin
          state_d = pcdt_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = pcdt_pkg::ST_IDLE;
      end
    endcase
  end

  // phase timer
  pcdt_phase_timer #(
    .W        (pcdt_pkg::CNT_W)
  ) u_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .load     (tmr_load),
    .load_val (tmr_val),
    .tick     (tick),
    .last     (tmr_last),
    .expire   (tmr_exp)
  );

  // state and direction registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= pcdt_pkg::ST_IDLE;
      dir_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == pcdt_pkg::ST_IDLE) begin
        dir_q <= dma_read_dir;
      end
    end
  end

  // terminal count
  logic       tc_seen_q;   // system terminal count captured this cycle
  logic       wait_seen_q; // card wait seen this cycle
  logic [2:0] cmd_age_q;   // core cycles since the command started, saturating
  logic       in_cmd;      // command strobe phase
  logic       in_cycle;    // setup through command
  logic       tc_window;   // card terminal count may be shown now

  assign in_cmd    = (state_q == pcdt_pkg::ST_CMD) || (state_q == pcdt_pkg::ST_HOLD);
  assign in_cycle  = (state_q == pcdt_pkg::ST_SETUP) || in_cmd;
  // both edges a whole lead inside the strobe; both share one register stage
  assign tc_window = in_cmd && tc_seen_q && (cmd_age_q >= 3'(pcdt_pkg::TC_EDGE_CYC)) &&
                     !(tmr_last && card_wait_n && (div_q >= 2'(pcdt_pkg::TICK_DIV - pcdt_pkg::TC_EDGE_CYC)));

  // capture terminal count and wait, count the command age
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tc_seen_q   <= 1'b0;
      wait_seen_q <= 1'b0;
      cmd_age_q   <= 3'h0;
    end else begin
      if (in_cycle && vpp_valid_tc) begin
        tc_seen_q <= 1'b1;
      end else if (state_q == pcdt_pkg::ST_IDLE) begin
        tc_seen_q <= 1'b0;
      end
      if (in_cmd && !card_wait_n) begin
        wait_seen_q <= 1'b1;
      end else if (state_q == pcdt_pkg::ST_IDLE) begin
        wait_seen_q <= 1'b0;
      end
      if (!in_cmd) begin
        cmd_age_q <= 3'h0;
      end else if (cmd_age_q != 3'h7) begin
        cmd_age_q <= cmd_age_q + 3'h1;
      end
    end
  end

  // card pin decode
  pcdt_pkg::pcdt_card_pins_t pins_d;  // next card pin values

  // read cycles command on the write strobe, write cycles on the read strobe
  always_comb begin
    pins_d = pcdt_pkg::PINS_IDLE;
    if (in_cycle) begin
      pins_d.low_en_n   = 1'b0;
      pins_d.high_en_n  = card_sixteen_bit_io_flag_n;
      pins_d.attr_sel_n = 1'b0;
      if (dir_q) begin
        pins_d.io_rd_n  = 1'b0;
        pins_d.mem_oe_n = 1'b0;
        pins_d.wdata_oe = 1'b1;
        pins_d.io_wr_n  = !in_cmd;
        pins_d.mem_we_n = !tc_window;
      end else begin
        pins_d.io_wr_n  = 1'b0;
        pins_d.mem_we_n = 1'b0;
        pins_d.io_rd_n  = !in_cmd;
        pins_d.mem_oe_n = !tc_window;
      end
    end
  end

  // system request gating
  logic [2:0] empty_cnt_q;  // cycles the request has waited on an empty buffer
  logic       req_ok;       // request held long enough over an empty buffer

  assign req_ok = (empty_cnt_q >= 3'(pcdt_pkg::REQ_HOLD_CYC - 1));

  // request waits until the buffer has drained for the least time
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      empty_cnt_q <= 3'h0;
    end else if (!(sock_transfer_request && sock_fifo_empty)) begin
      empty_cnt_q <= 3'h0;
    end else if (!req_ok) begin
      empty_cnt_q <= empty_cnt_q + 3'h1;
    end
  end

  // output registers
  logic [7:0] rdata_d;  // read mux result

  // read mux: timing registers, status, zero elsewhere
  assign rdata_d = idx_hit ? tmr_q[wr_slot] :
                   (reg_index == pcdt_pkg::IDX_STATUS) ?
                   {state_q, tc_seen_q, wait_seen_q, interrupt_line_ten, dir_q, 1'b0} : 8'h00;

  // every top-level output comes from a flip-flop
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      card_pins          <= pcdt_pkg::PINS_IDLE;
      interrupt_line_ten <= 1'b0;
      dma_cycle_done     <= 1'b0;
      reg_rdata          <= 8'h00;
    end else begin
      card_pins          <= pins_d;
      interrupt_line_ten <= sock_transfer_request && sock_fifo_empty && req_ok;
      dma_cycle_done     <= (state_q == pcdt_pkg::ST_RECOV) && tmr_exp;
      reg_rdata          <= rdata_d;
    end
  end

endmodule

`default_nettype wire

/* File: pcdt_pkg.sv */
// Purpose: shared constants, types and states for the socket dma cycle sequencer
// Assumes: core clock of 100 MHz; phase timing counted in 40 ns internal periods
// Notes:   card-side strobes are active low; timer set values are eight bits wide
`default_nettype none

package pcdt_pkg;

  // register indices
  localparam logic [7:0] IDX_SETUP_SET0   = 8'h3A;  // setup phase count, timer set 0
  localparam logic [7:0] IDX_COMMAND_SET0 = 8'h3B;  // command phase count, timer set 0
  localparam logic [7:0] IDX_RECOVER_SET0 = 8'h3C;  // recovery phase count, timer set 0
  localparam logic [7:0] IDX_SETUP_SET1   = 8'h3D;  // setup phase count, timer set 1
  localparam logic [7:0] IDX_COMMAND_SET1 = 8'h3E;  // command phase count, timer set 1
  localparam logic [7:0] IDX_RECOVER_SET1 = 8'h3F;  // recovery phase count, timer set 1
  localparam logic [7:0] IDX_STATUS       = 8'h38;  // read-only sequencer status

  // timing register reset values, index order
  localparam logic [7:0] RST_SETUP_SET0   = 8'h01;
  localparam logic [7:0] RST_COMMAND_SET0 = 8'h06;
  localparam logic [7:0] RST_RECOVER_SET0 = 8'h03;
  localparam logic [7:0] RST_SETUP_SET1   = 8'h01;
  localparam logic [7:0] RST_COMMAND_SET1 = 8'h06;
  localparam logic [7:0] RST_RECOVER_SET1 = 8'h03;
  localparam int         NUM_TMR_REGS     = 6;

  // status register field positions
  localparam int ST_STATE_LSB = 5;  // bits 7:5 hold the sequencer state
  localparam int ST_TC_BIT    = 4;  // terminal count captured for this cycle
  localparam int ST_WAIT_BIT  = 3;  // card wait seen active
  localparam int ST_REQ_BIT   = 2;  // request presented to the system
  localparam int ST_DIR_BIT   = 1;  // direction of the cycle in flight

  // timing figures and derived cycle counts
  localparam int CLK_PERIOD_NS  = 10;  // core clock period
  localparam int TCP_NS         = 40;  // internal phase clock period
  localparam int TICK_DIV       = TCP_NS / CLK_PERIOD_NS;
  localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);
  localparam int START_NS       = 40;  // least delay from request to cycle begin
  localparam int START_TICKS    = (START_NS + TCP_NS - 1) / TCP_NS;
  localparam int TC_EDGE_NS     = 25;  // least gap from strobe edge to card count edge
  localparam int TC_EDGE_CYC    = (TC_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_HOLD_TICKS = 2;  // least strobe hold after card wait release
  localparam int REQ_HOLD_NS    = 40;  // least delay from buffer empty to system request
  localparam int REQ_HOLD_CYC   = (REQ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // phase counter width
  localparam int CNT_W = 17;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,  // waiting for request and acknowledge
    ST_START = 3'b001,  // least delay before the cycle begins
    ST_SETUP = 3'b010,  // address, enables and setup strobes driven
    ST_CMD   = 3'b011,  // command strobe active, programmed length
    ST_HOLD  = 3'b100,  // command stretched by card wait
    ST_RECOV = 3'b101   // command off, recovery time
  } pcdt_state_t;

  // card-side pin group, strobes active low
  typedef struct packed {
    logic low_en_n;   // card_low_byte_enable, active low
    logic high_en_n;  // card_high_byte_enable, active low
    logic attr_sel_n; // attribute space select, active low
    logic io_rd_n;    // io_read_strobe, active low
    logic io_wr_n;    // io_write_strobe, active low
    logic mem_oe_n;   // memory output enable, active low
    logic mem_we_n;   // memory write enable, active low
    logic wdata_oe;   // write data driven onto the card bus
  } pcdt_card_pins_t;

  localparam pcdt_card_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

endpackage

`default_nettype wire

/* File: pcdt_phase_timer.sv */
// Purpose: down-counter that times one phase in internal clock periods
// Assumes: tick is a one-cycle enable every internal period
// Notes:   expire pulses on the tick that takes the count from one to zero
`timescale 1ns/10ps
`default_nettype none

module pcdt_phase_timer #(
  parameter int W = 17
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // control
  input  wire logic         load,      // load a new phase length
  input  wire logic [W-1:0] load_val,  // phase length in internal periods
  input  wire logic         tick,      // internal period enable
  // status
  output logic              last,      // final period of the phase
  output logic              expire     // phase ends on this cycle
);

  logic [W-1:0] cnt_q;  // periods left in the phase
  logic [W-1:0] cnt_d;

  // next count: load wins, else count down on each tick until zero
  assign cnt_d  = load ? load_val : ((tick && (cnt_q != '0)) ? (cnt_q - W'(1)) : cnt_q);
  assign last   = (cnt_q == W'(1));
  assign expire = last && tick;

  // count register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

`default_nettype wire

/* File: pcdt_dma_seq_sva.sv */
// Purpose: port assertions for the socket dma cycle sequencer
// Assumes: one clock, sync active-low reset, 4 core clocks a period
// Notes:   mirrors the timing registers to get phase lengths
`timescale 1ns/10ps
`default_nettype none
module pcdt_dma_seq_sva (
  // clock and reset
  input wire logic                      core_clk,
  input wire logic                      rstn,
  // register port and configuration
  input wire logic [7:0]                reg_index,
  input wire logic                      reg_wr_en,
  input wire logic [7:0]                reg_wdata,
  input wire logic                      timer_set_sel,
  input wire logic [7:0]                phase_prescale_factor,
  input wire logic                      dma_read_dir,
  // system and socket
  input wire logic                      interrupt_line_nine_n,
  input wire logic                      interrupt_line_ten,
  input wire logic                      vpp_valid_tc,
  input wire logic                      dma_cycle_done,
  input wire logic                      sock_transfer_request,
  input wire logic                      sock_fifo_empty,
  input wire logic                      card_wait_n,
  input wire pcdt_pkg::pcdt_card_pins_t card_pins
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [7:0] tmr_q [6]; // timing register mirror
  int         low_cnt, en_cnt, rec_cnt, rel_cnt; // phase length counters
  int         s_cyc, c_cyc, r_cyc; // expected lengths in core clocks
  logic       waited_q, tc_seen_q; // wait seen, system count seen
  wire  [2:0] base     = timer_set_sel ? 3'h3 : 3'h0;
  wire        cmd_n    = dma_read_dir ? card_pins.io_wr_n : card_pins.io_rd_n;
  wire        tc_n     = dma_read_dir ? card_pins.mem_we_n : card_pins.mem_oe_n;
  wire        src      = sock_transfer_request && sock_fifo_empty;
  wire        both_act = interrupt_line_ten && !interrupt_line_nine_n;
  wire        setup_ok = !card_pins.low_en_n && !card_pins.attr_sel_n && (dma_read_dir ?
                         (!card_pins.io_rd_n && !card_pins.mem_oe_n && card_pins.wdata_oe) :
                         (!card_pins.io_wr_n && !card_pins.mem_we_n));
  assign s_cyc = 4 * (int'(phase_prescale_factor) * int'(tmr_q[base]) + 1);
  assign c_cyc = 4 * (int'(phase_prescale_factor) * int'(tmr_q[base + 3'h1]) + 1);
  assign r_cyc = 4 * (int'(phase_prescale_factor) * int'(tmr_q[base + 3'h2]) + 1);
  // mirror register writes; set 1 starts equal to set 0
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tmr_q <= '{8'h01, 8'h06, 8'h03, 8'h01, 8'h06, 8'h03};
    end else if (reg_wr_en && reg_index >= 8'h3A && reg_index <= 8'h3F) begin
      tmr_q[reg_index - 8'h3A] <= reg_wdata;
    end
  end
  // phase length counters
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      low_cnt   <= 0;
      en_cnt    <= 0;
      rec_cnt   <= 0;
      rel_cnt   <= 0;
      waited_q  <= 1'b0;
      tc_seen_q <= 1'b0;
    end else begin
      low_cnt   <= cmd_n ? 0 : low_cnt + 1;
      en_cnt    <= card_pins.low_en_n ? 0 : en_cnt + int'(cmd_n);
      rec_cnt   <= cmd_n ? rec_cnt + 1 : 0;
      rel_cnt   <= card_wait_n ? rel_cnt + 1 : 0;
      waited_q  <= !cmd_n && (waited_q || !card_wait_n);
      tc_seen_q <= card_pins.low_en_n ? vpp_valid_tc : (tc_seen_q || vpp_valid_tc);
    end
  end
  property p_req_block; !src |=> !interrupt_line_ten; endproperty
  a_req_block: assert property (p_req_block) else $error("request while busy");
  property p_req_rise; $rose(interrupt_line_ten) |-> $past(src, 1) && $past(src, 2) && $past(src, 3); endproperty
  a_req_rise: assert property (p_req_rise) else $error("request early");
  property p_req_bound; src [*7] |-> interrupt_line_ten; endproperty
  a_req_bound: assert property (p_req_bound) else $error("request missing");
  property p_start; $fell(card_pins.low_en_n) |-> $past(both_act, 5); endproperty
  a_start: assert property (p_start) else $error("cycle early");
  property p_setup; $fell(cmd_n) |-> en_cnt == s_cyc && $past(setup_ok); endproperty
  a_setup: assert property (p_setup) else $error("setup phase wrong");
  property p_cmd; $rose(cmd_n) && !waited_q |-> low_cnt == c_cyc; endproperty
  a_cmd: assert property (p_cmd) else $error("command length wrong");
  property p_recov; $rose(dma_cycle_done) |-> rec_cnt >= r_cyc - 1 && rec_cnt <= r_cyc + 1; endproperty
  a_recov: assert property (p_recov) else $error("recovery wrong");
  property p_wait; $rose(cmd_n) && waited_q |-> rel_cnt >= 8; endproperty
  a_wait: assert property (p_wait) else $error("wait hold short");
  property p_tc_in; $fell(tc_n) |-> !cmd_n && low_cnt >= 3 && low_cnt <= 5 && tc_seen_q; endproperty
  a_tc_in: assert property (p_tc_in) else $error("card count start wrong");
  property p_tc_end; $rose(tc_n) && !cmd_n && !waited_q |-> ##[3:5] $rose(cmd_n); endproperty
  a_tc_end: assert property (p_tc_end) else $error("card count end wrong");
endmodule
bind pcdt_dma_seq pcdt_dma_seq_sva pcdt_dma_seq_sva_i (.*);
`default_nettype wire

/* File: pcdt_card_model.sv */
// Purpose: system acknowledge and inserted card as seen from the socket pins
// Assumes: one acknowledge per request, dropped once the card enables go low
// Notes:   wait is pulled up, so a released wait reads high
`timescale 1ns/10ps
`default_nettype none
module pcdt_card_model (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  // controls from the bench
  input  wire logic                      dir_rd,
  input  wire logic [7:0]                wait_len,
  // device pins
  input  wire logic                      interrupt_line_ten,
  input  wire pcdt_pkg::pcdt_card_pins_t card_pins,
  output logic                           interrupt_line_nine_n,
  output logic                           card_wait_n,
  output logic                           card_sixteen_bit_io_flag_n
);
  logic       armed_q;  // one acknowledge per request
  logic [7:0] wcnt_q;   // cycles since the command strobe fell
  wire        cmd_n = dir_rd ? card_pins.io_wr_n : card_pins.io_rd_n;
  // sixteen-bit card, flag steady before any strobe
  assign card_sixteen_bit_io_flag_n = 1'b0;
  // acknowledge the request, stretch the command when asked
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      armed_q               <= 1'b1;
      interrupt_line_nine_n <= 1'b1;
      wcnt_q                <= 8'h00;
      card_wait_n           <= 1'b1;
    end else begin
      armed_q               <= !interrupt_line_ten || (armed_q && card_pins.low_en_n);
      interrupt_line_nine_n <= !(interrupt_line_ten && armed_q && card_pins.low_en_n);
      wcnt_q                <= cmd_n ? 8'h00 : wcnt_q + 8'h01;
      // wait falls early, well inside the allowed window
      card_wait_n           <= !(wait_len != 8'h00 && wcnt_q >= 8'h03 && wcnt_q < 8'h03 + wait_len);
    end
  end
endmodule
`default_nettype wire

/* File: pc_card_dma_cycle_timing_bench.sv */
// Purpose: self-checking bench for the socket dma cycle sequencer
// Assumes: inputs change on the falling clock edge
// Notes:   phase lengths are four core clocks per internal period
`timescale 1ns/10ps
`default_nettype none
module pc_card_dma_cycle_timing_bench;
  logic                      core_clk = 1'b0;
  logic                      rstn = 1'b0;
  logic [7:0]                reg_index = 8'h00, reg_wdata = 8'h00, prescale = 8'h01, wait_len = 8'h00;
  logic                      reg_wr_en = 1'b0, set_sel = 1'b0, rd_dir = 1'b1, vpp_tc = 1'b0;
  logic                      sock_req = 1'b0, fifo_empty = 1'b0;
  logic [7:0]                reg_rdata;
  logic                      ack_n, line_ten, cycle_done, wait_n, flag_n;
  pcdt_pkg::pcdt_card_pins_t card_pins;
  int                        num_errors = 0, comparisons = 0;
  // 100 MHz core clock
  always #5 core_clk = ~core_clk;
  pcdt_dma_seq pcdt_dma_seq_i (.core_clk, .rstn, .reg_index, .reg_wr_en, .reg_wdata, .reg_rdata,
    .timer_set_sel(set_sel), .phase_prescale_factor(prescale), .dma_read_dir(rd_dir),
    .interrupt_line_nine_n(ack_n), .interrupt_line_ten(line_ten), .vpp_valid_tc(vpp_tc),
    .dma_cycle_done(cycle_done), .sock_transfer_request(sock_req), .sock_fifo_empty(fifo_empty),
    .card_wait_n(wait_n), .card_sixteen_bit_io_flag_n(flag_n), .card_pins);
  pcdt_card_model pcdt_card_model_i (.core_clk, .rstn, .dir_rd(rd_dir), .wait_len,
    .interrupt_line_ten(line_ten), .card_pins, .interrupt_line_nine_n(ack_n), .card_wait_n(wait_n),
    .card_sixteen_bit_io_flag_n(flag_n));
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one register write, one cycle long
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
    @(negedge core_clk);
    reg_index = idx;
    reg_wdata = val;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
  endtask
  // read data follows the index one edge later
  task automatic reg_chk(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] exp);
    @(negedge core_clk);
    reg_index = idx;
    @(negedge core_clk);
    check("reg_rdata", reg_rdata & mask, exp);
  endtask
  // reset values, write back, read-only status, unmapped index
  task automatic t_regs();
    logic [7:0] rst_v [3] = '{8'h01, 8'h06, 8'h03};
    for (int i = 0; i < 3; i++) begin
      reg_chk(8'h3A + 8'(i), 8'hFF, rst_v[i]);
    end
    reg_wr(8'h3D, 8'h02);
    reg_wr(8'h3E, 8'h04);
    reg_wr(8'h3F, 8'h01);
    reg_chk(8'h3E, 8'hFF, 8'h04);
    reg_wr(8'h38, 8'hFF);
    reg_chk(8'h38, 8'hFC, 8'h00);
    reg_wr(8'h40, 8'h55);
    reg_chk(8'h40, 8'hFF, 8'h00);
    $display("test registers done");
  endtask
  // one dma cycle, request held off until the buffer drains
  task automatic t_cycle(input logic rd, input logic set, input logic [7:0] pres, input logic tc,
                         input logic [7:0] wl, input int exp_cmd, input string name);
    int   cmd_cnt = 0;
    int   tc_cnt = 0;
    logic done_seen = 1'b0;
    @(negedge core_clk);
    rd_dir = rd;
    set_sel = set;
    prescale = pres;
    vpp_tc = tc;
    wait_len = wl;
    sock_req = 1'b1;
    fifo_empty = 1'b0;
    repeat (8) @(negedge core_clk);
    check("request with buffer busy", line_ten, 1'b0);
    fifo_empty = 1'b1;
    for (int n = 0; n < 2000 && !done_seen; n++) begin
      @(negedge core_clk);
      cmd_cnt += int'(rd ? !card_pins.io_wr_n : !card_pins.io_rd_n);
      tc_cnt += int'(rd ? !card_pins.mem_we_n : !card_pins.mem_oe_n);
      done_seen = (cycle_done === 1'b1);
    end
    sock_req = 1'b0;
    check("cycle done", done_seen, 1'b1);
    if (!done_seen) begin
      summarize();
    end
    if (wl == 8'h00) begin
      check("command length", cmd_cnt, exp_cmd);
    end else begin
      check("stretched command", cmd_cnt >= exp_cmd, 1'b1);
    end
    check("card terminal count", tc_cnt != 0, tc);
    $display("test %s done", name);
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    repeat (2) @(negedge core_clk);
    t_regs();
    t_cycle(1'b1, 1'b0, 8'h01, 1'b1, 8'h00, 28, "read default");
    t_cycle(1'b1, 1'b0, 8'h00, 1'b0, 8'h00, 4, "read minimum");
    t_cycle(1'b0, 1'b1, 8'h02, 1'b1, 8'h32, 61, "write with wait");
    summarize();
  end
endmodule
`default_nettype wire
